// >>> logic/vic_ctrl.v
/*
  Vectored interrupt controller with the two shared I/O ports that feed its
  external pins. Six pending latches, master enable, four-bit mask, fixed
  priority, vectoring and save/restore of program counter and flags.
  Assumes the processor core runs on clk, pulses instr_done at the end of
  each instruction, and raises count_busy while a counter step is pending.
*/
`timescale 1ns/1ps
`include "vic_defs.vh"

module vic_ctrl
(
  input  wire                     clk,
  input  wire                     rst,
  // core instruction interface
  input  wire                     instr_done,
  input  wire                     count_busy,
  input  wire [`VIC_PC_W-1:0]     core_pc,
  input  wire [`VIC_FLAG_W-1:0]   core_flags,
  input  wire                     return_from_irq,
  input  wire                     enable_and_clear_instr,
  input  wire                     disable_and_clear_instr,
  input  wire                     clear_latch_instr,
  input  wire [5:0]               latch_clear_sel,
  input  wire                     mask_wr,
  input  wire [3:0]               mask_wdata,
  output reg  [3:0]               irq_enable_mask_reg,
  output reg                      master_irq_enable_reg,
  output reg  [5:0]               pending_reg,
  output reg                      irq_accept_reg,
  output reg  [`VIC_PC_W-1:0]     vector_pc_reg,
  output reg                      status_force_reg,
  output reg                      restore_valid_reg,
  output wire [`VIC_STK_W-1:0]    restore_data,
  // internal event sources
  input  wire                     serial_transfer_irq,
  input  wire                     counter_one_overflow_irq,
  input  wire                     counter_two_overflow_irq,
  input  wire                     divider_tick_irq,
  // shared external port
  input  wire                     ext_port_wr,
  input  wire [3:0]               ext_port_wdata,
  output reg  [3:0]               ext_port_rdata_reg,
  input  wire [3:0]               ext_shared_port_in,
  output reg  [3:0]               ext_shared_port_out_reg,
  output reg  [3:0]               ext_shared_port_oe_n_reg,
  // shared serial port
  input  wire                     ser_port_wr,
  input  wire [2:0]               ser_port_wdata,
  output reg  [3:0]               ser_port_rdata_reg,
  input  wire                     serial_enable,
  input  wire [2:0]               serial_drive_low,
  input  wire [2:0]               serial_shared_port_in,
  output reg  [2:0]               serial_shared_port_out_reg,
  output reg  [2:0]               serial_shared_port_oe_n_reg
);

  localparam ST_IDLE   = 2'd0;
  localparam ST_WAIT   = 2'd1;
  localparam ST_ACCEPT = 2'd2;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // highest-priority set bit of a request vector, as a one-hot
  function [5:0] pick_winner;
    input [5:0] req;
    begin
      if (req[5])
        pick_winner = 6'h20;
      else if (req[4])
        pick_winner = 6'h10;
      else if (req[3])
        pick_winner = 6'h08;
      else if (req[2])
        pick_winner = 6'h04;
      else if (req[1])
        pick_winner = 6'h02;
      else if (req[0])
        pick_winner = 6'h01;
      else
        pick_winner = 6'h00;
    end
  endfunction

  function [`VIC_PC_W-1:0] vector_of;
    input [5:0] onehot;
    begin
      case (onehot)
        6'h20:   vector_of = `VIC_VEC_HIGH_EXT;
        6'h10:   vector_of = `VIC_VEC_SERIAL;
        6'h08:   vector_of = `VIC_VEC_CNT1;
        6'h04:   vector_of = `VIC_VEC_CNT2;
        6'h02:   vector_of = `VIC_VEC_DIV;
        default: vector_of = `VIC_VEC_LOW_EXT;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  reg [3:0] ext_meta_reg;
  reg [3:0] ext_sync_reg;
  reg [3:0] ext_prev_reg;
  reg [2:0] ser_meta_reg;
  reg [2:0] ser_sync_reg;
  reg [3:0] int_prev_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_meta_reg <= 4'hF;
      ext_sync_reg <= 4'hF;
      ext_prev_reg <= 4'hF;
      ser_meta_reg <= 3'h7;
      ser_sync_reg <= 3'h7;
      int_prev_reg <= 4'h0;
    end
    else
    begin
      ext_meta_reg <= ext_shared_port_in;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      ser_meta_reg <= serial_shared_port_in;
      ser_sync_reg <= ser_meta_reg;
      int_prev_reg <= {serial_transfer_irq, counter_one_overflow_irq,
                       counter_two_overflow_irq, divider_tick_irq};
    end
  end

  wire [3:0] int_now = {serial_transfer_irq, counter_one_overflow_irq,
                        counter_two_overflow_irq, divider_tick_irq};
  wire [3:0] int_rise = int_now & ~int_prev_reg; // see (R22)
  // the pin is sensed whatever drives it, so port output use also trips it
  wire high_fall = ext_prev_reg[`VIC_PIN_HIGH_EXT] & ~ext_sync_reg[`VIC_PIN_HIGH_EXT]; // see (R3) see (R22)
  wire low_fall  = ext_prev_reg[`VIC_PIN_LOW_EXT]  & ~ext_sync_reg[`VIC_PIN_LOW_EXT];  // see (R22)
  wire [5:0] pend_set = {high_fall, int_rise, low_fall}; // see (R8) see (R9)

  // ---------------------------------------------------------------
  // acceptance gating and priority
  // ---------------------------------------------------------------
  wire [5:0] enable_cond;
  assign enable_cond[5] = master_irq_enable_reg; // see (R12)
  assign enable_cond[4] = master_irq_enable_reg & irq_enable_mask_reg[`VIC_MASK_SERIAL]; // see (R11)
  assign enable_cond[3] = master_irq_enable_reg & irq_enable_mask_reg[`VIC_MASK_CNT1];
  assign enable_cond[2] = master_irq_enable_reg & irq_enable_mask_reg[`VIC_MASK_CNT2_DIV]; // see (R13)
  assign enable_cond[1] = master_irq_enable_reg & irq_enable_mask_reg[`VIC_MASK_CNT2_DIV]; // see (R13)
  assign enable_cond[0] = master_irq_enable_reg & irq_enable_mask_reg[`VIC_MASK_LOW_EXT]; // see (R4)

  // a masked source never blocks a lower enabled one
  wire [5:0] winner = pick_winner(pending_reg & enable_cond); // see (R10)

  // ---------------------------------------------------------------
  // acceptance sequencer
  // ---------------------------------------------------------------
  reg [1:0]               state_reg;
  reg [1:0]               state_next;
  reg [5:0]               grant_reg;
  reg [`VIC_STK_AW-1:0]   sp_reg;
  reg                     pop_pend_reg;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (instr_done && (winner != 6'h00) && !return_from_irq)
          state_next = count_busy ? ST_WAIT : ST_ACCEPT; // see (R15)
      end
      ST_WAIT:
      begin
        // a counter step finishes before acceptance
        if (!count_busy)
          state_next = ST_ACCEPT; // see (R15)
      end
      ST_ACCEPT:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  wire take_now = (state_reg == ST_ACCEPT);
  // winner is frozen on entry so a clear in the meantime cannot mis-vector
  wire [5:0] grant_next = (state_reg == ST_IDLE) ? winner : grant_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg         <= ST_IDLE;
      grant_reg         <= 6'h00;
      irq_accept_reg    <= 1'b0;
      vector_pc_reg     <= {`VIC_PC_W{1'b0}};
      status_force_reg  <= 1'b0;
      sp_reg            <= {`VIC_STK_AW{1'b0}};
      pop_pend_reg      <= 1'b0;
      restore_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      grant_reg         <= grant_next;
      irq_accept_reg    <= take_now;
      status_force_reg  <= take_now; // see (R18)
      if (take_now)
        vector_pc_reg <= vector_of(grant_reg); // see (R17)
      if (take_now)
        sp_reg <= sp_reg + 1'b1; // see (R16)
      else if (return_from_irq)
        sp_reg <= sp_reg - 1'b1; // see (R21)
      pop_pend_reg      <= return_from_irq & ~take_now;
      restore_valid_reg <= pop_pend_reg; // see (R21)
    end
  end

  // the top word sits below the pointer, but once a pop has stepped the
  // pointer down it sits at the pointer itself; reading it there keeps
  // restore_data aligned with restore_valid_reg one cycle later
  wire [`VIC_STK_AW-1:0] pop_addr = pop_pend_reg ? sp_reg : (sp_reg - 1'b1); // see (R21)

  vic_stack_mem u_stack
  (
    .clk         (clk),
    .rst         (rst),
    .wr_en       (take_now),
    .wr_addr     (sp_reg),
    .wr_data     ({core_flags, core_pc}),
    .rd_addr     (pop_addr),
    .rd_data_reg (restore_data)
  );

  // ---------------------------------------------------------------
  // master enable, mask and pending latches
  // ---------------------------------------------------------------
  wire [5:0] instr_clear = (enable_and_clear_instr | disable_and_clear_instr | clear_latch_instr)
                           ? latch_clear_sel : 6'h00;
  wire [5:0] accept_clear = take_now ? grant_reg : 6'h00; // see (R20)

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      master_irq_enable_reg <= 1'b0; // see (R23)
      irq_enable_mask_reg   <= `VIC_MASK_RST;
      pending_reg           <= `VIC_PEND_RST;
    end
    else
    begin
      if (take_now)
        master_irq_enable_reg <= 1'b0; // see (R19)
      else if (return_from_irq || enable_and_clear_instr)
        master_irq_enable_reg <= 1'b1; // see (R21) see (R23)
      else if (disable_and_clear_instr)
        master_irq_enable_reg <= 1'b0; // see (R23)
      if (mask_wr)
        irq_enable_mask_reg <= mask_wdata; // see (R11)
      // a new edge wins over any clear in the same cycle
      pending_reg <= (pending_reg & ~(instr_clear | accept_clear)) | pend_set; // see (R14)
    end
  end

  // ---------------------------------------------------------------
  // shared ports
  // ---------------------------------------------------------------
  // pins are pulled up; a latch of one releases the pin for outside drivers, unless serial_drive_low pulls a serial pin low
  reg [3:0] ext_latch_reg;
  reg [2:0] ser_latch_reg;
  wire [2:0] ser_low = ~ser_latch_reg | (serial_enable ? serial_drive_low : 3'h0); // see (R7)

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_latch_reg               <= `VIC_EXT_LATCH_RST;
      ser_latch_reg               <= `VIC_SER_LATCH_RST;
      ext_port_rdata_reg          <= 4'hF;
      ser_port_rdata_reg          <= 4'hF;
      ext_shared_port_out_reg     <= 4'hF;
      ext_shared_port_oe_n_reg    <= 4'hF;
      serial_shared_port_out_reg  <= 3'h7;
      serial_shared_port_oe_n_reg <= 3'h7;
    end
    else
    begin
      if (ext_port_wr)
        ext_latch_reg <= ext_port_wdata; // see (R1) see (R2)
      if (ser_port_wr)
        ser_latch_reg <= ser_port_wdata; // see (R5)
      ext_shared_port_out_reg     <= ext_latch_reg;
      ext_shared_port_oe_n_reg    <= ext_latch_reg;
      serial_shared_port_out_reg  <= ~ser_low;
      serial_shared_port_oe_n_reg <= ~ser_low; // see (R5)
      ext_port_rdata_reg          <= ext_sync_reg;
      ser_port_rdata_reg          <= {1'b1, ser_sync_reg}; // see (R6)
    end
  end

endmodule

// >>> logic/vic_defs.vh
/*
  Constants for the vectored interrupt controller: source indices, vectors,
  mask bit positions, reset values and stack geometry.
  Assumes the includer is plain Verilog-2005 and clocked at 125 MHz.
*/
// Summary of operation
// (R1) software writes ones to the external shared port latch before input use
// (R2) shared pin latch holds one while an outside circuit drives it
// (R3) high external pending latch sets on any pin falling edge, even as output
// (R4) low external request never accepted while mask bit 0 is clear
// (R5) serial shared port has three latched two-way pins, one for input
// (R6) unimplemented fourth serial port bit always reads one
// (R7) serial port pins act as plain I/O while serial function is off
// (R8) six sources: two external pins, serial, two counter overflows, divider tick
// (R9) each source has a pending latch set by an edge, raising a request
// (R10) accept only the fixed-priority winner whose enable condition holds
// (R11) master enable and four-bit mask gate acceptance, bits per source group
// (R12) high external source has no mask bit, needs only master enable
// (R13) counter two overflow and divider tick share one mask bit
// (R14) pending latch holds until accepted, initialised or cleared by instruction
// (R15) acceptance within two instruction cycles, after any pending count finishes
// (R16) acceptance pushes program counter and flags onto the stack
// (R17) acceptance loads vector 002 to 00C by priority into program counter
// (R18) acceptance forces the status flag to one
// (R19) acceptance clears master enable until software or return sets it
// (R20) acceptance clears only the accepted source's pending latch
// (R21) return instruction pops counter and flags and sets master enable
// (R22) internal latches set on rising edge, external on falling pin edge
// (R23) dedicated instructions set or clear master enable; initialisation clears all
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// pending latch indices, index 5 is the highest priority
`define VIC_SRC_HIGH_EXT   3'd5
`define VIC_SRC_SERIAL     3'd4
`define VIC_SRC_CNT1       3'd3
`define VIC_SRC_CNT2       3'd2
`define VIC_SRC_DIV        3'd1
`define VIC_SRC_LOW_EXT    3'd0
`define VIC_NSRC           6

// vector addresses
`define VIC_VEC_HIGH_EXT   12'h002
`define VIC_VEC_SERIAL     12'h004
`define VIC_VEC_CNT1       12'h006
`define VIC_VEC_CNT2       12'h008
`define VIC_VEC_DIV        12'h00A
`define VIC_VEC_LOW_EXT    12'h00C

// enable mask bit positions
`define VIC_MASK_LOW_EXT   0
`define VIC_MASK_CNT2_DIV  1
`define VIC_MASK_CNT1      2
`define VIC_MASK_SERIAL    3

// shared port pin positions
`define VIC_PIN_HIGH_EXT   2
`define VIC_PIN_LOW_EXT    0

// reset values
`define VIC_MASK_RST       4'h0
`define VIC_PEND_RST       6'h00
`define VIC_EXT_LATCH_RST  4'hF
`define VIC_SER_LATCH_RST  3'h7

// stack geometry: 12-bit program counter plus 4 flags
`define VIC_PC_W           12
`define VIC_FLAG_W         4
`define VIC_STK_W          16
`define VIC_STK_AW         4

`endif

// >>> logic/vic_stack_mem.v
/*
  Save stack for program counter and flags, one write port and one read
  port with registered read data.
  Assumes a single clock shared with the controller.
*/
`timescale 1ns/1ps
`include "vic_defs.vh"

module vic_stack_mem
(
  input  wire                     clk,
  input  wire                     rst,
  input  wire                     wr_en,
  input  wire [`VIC_STK_AW-1:0]   wr_addr,
  input  wire [`VIC_STK_W-1:0]    wr_data,
  input  wire [`VIC_STK_AW-1:0]   rd_addr,
  output reg  [`VIC_STK_W-1:0]    rd_data_reg
);

  reg [`VIC_STK_W-1:0] mem [0:(1<<`VIC_STK_AW)-1];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data is registered so the controller outputs come straight from a flop
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_reg <= {`VIC_STK_W{1'b0}};
    end
    else
    begin
      rd_data_reg <= mem[rd_addr];
    end
  end

endmodule

// >>> test/vic_props.sv
/*
  Port assertions for vic_ctrl, bound into every instance.
  Assumes one clock domain and an asynchronous active-high rst.
*/
`timescale 1ns/1ps
module vic_props
(
  input wire        clk,
  input wire        rst,
  input wire        instr_done,
  input wire        count_busy,
  input wire        return_from_irq,
  input wire        enable_and_clear_instr,
  input wire        disable_and_clear_instr,
  input wire        clear_latch_instr,
  input wire        mask_wr,
  input wire [3:0]  mask_wdata,
  input wire [3:0]  irq_enable_mask_reg,
  input wire        master_irq_enable_reg,
  input wire [5:0]  pending_reg,
  input wire        irq_accept_reg,
  input wire [11:0] vector_pc_reg,
  input wire        status_force_reg,
  input wire        restore_valid_reg,
  input wire [3:0]  ser_port_rdata_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------
  // assertions
  // ----------
  a_accept_drops_master: assert property (irq_accept_reg |-> !master_irq_enable_reg)
    else $error("master enable still set at accept");
  a_accept_forces_status: assert property (irq_accept_reg |-> status_force_reg)
    else $error("status not forced at accept");
  a_vector_legal: assert property (irq_accept_reg |-> vector_pc_reg inside {12'h002, 12'h004, 12'h006,
    12'h008, 12'h00A, 12'h00C})
    else $error("vector outside table");
  a_spare_bit_one: assert property (ser_port_rdata_reg[3])
    else $error("spare serial bit not one");
  a_mask_write_lands: assert property (mask_wr |=> irq_enable_mask_reg == $past(mask_wdata))
    else $error("mask write lost");
  a_return_sets_master: assert property (return_from_irq && !irq_accept_reg |=> master_irq_enable_reg)
    else $error("return left master clear");
  a_pending_holds: assert property ((($past(pending_reg) & ~pending_reg) != 6'h00) |-> irq_accept_reg ||
    $past(clear_latch_instr || enable_and_clear_instr || disable_and_clear_instr))
    else $error("pending dropped without cause");
  a_low_ext_masked: assert property (irq_accept_reg && vector_pc_reg == 12'h00C |-> irq_enable_mask_reg[0])
    else $error("low external accepted while masked");
  a_accept_after_count: assert property (irq_accept_reg |-> !$past(count_busy, 2))
    else $error("accept while a count step was pending");
  c_high_ext: cover property (irq_accept_reg && vector_pc_reg == 12'h002);
  c_low_ext: cover property (irq_accept_reg && vector_pc_reg == 12'h00C);
  c_restore: cover property (restore_valid_reg);
endmodule
bind vic_ctrl vic_props u_vic_props (.*);

// >>> test/vic_core_model.sv
/*
  Core stand-in: retires an instruction every few cycles, stalls on
  every other one for a count step, jumps to the vector on acceptance.
  Assumes the controller shares clk and rst.
*/
`timescale 1ns/1ps
module vic_core_model
(
  input  wire        clk,
  input  wire        rst,
  input  wire        irq_accept_reg,
  input  wire [11:0] vector_pc_reg,
  output reg         instr_done,
  output reg         count_busy,
  output reg  [11:0] core_pc,
  output wire [3:0]  core_flags
);
  reg [1:0] phase;
  reg       slow;
  assign core_flags = core_pc[5:2] ^ 4'hA;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      phase <= 2'h0;
      slow <= 1'b0;
      instr_done <= 1'b0;
      count_busy <= 1'b0;
      core_pc <= 12'h100;
    end
    else
    begin
      // every other instruction ends with a count step that stands with its
      // done pulse and one cycle more, so acceptance has to wait it out
      count_busy <= ((phase == 2'h2) && slow) || (instr_done && count_busy);
      if (instr_done)
        slow <= ~slow;
      if (irq_accept_reg)
        core_pc <= vector_pc_reg;
      else if (instr_done)
        core_pc <= core_pc + 12'h001;
      phase <= phase + 2'h1;
      instr_done <= (phase == 2'h2);
    end
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench for vic_ctrl: priority, masks, vectors, ports.
  Assumes vic_core_model plays the core and released pins float high.
*/
`timescale 1ns/1ps
module testbench;
  reg clk = 0, rst = 1, return_from_irq = 0, enable_and_clear_instr = 0, disable_and_clear_instr = 0;
  reg clear_latch_instr = 0, mask_wr = 0, ext_port_wr = 0, ser_port_wr = 0, serial_enable = 0;
  reg [5:0] latch_clear_sel = 0;
  reg [3:0] mask_wdata = 0, ext_port_wdata = 0, ext_drv = 4'hF, int_src = 0;
  reg [2:0] ser_port_wdata = 0, serial_drive_low = 0;
  reg [7:0] lfsr = 8'h5A;
  wire instr_done, count_busy, master_irq_enable_reg, irq_accept_reg, status_force_reg, restore_valid_reg;
  wire [11:0] core_pc, vector_pc_reg;
  wire [3:0] core_flags, irq_enable_mask_reg, ext_port_rdata_reg, ext_shared_port_out_reg;
  wire [3:0] ext_shared_port_oe_n_reg, ser_port_rdata_reg, ext_shared_port_in;
  wire [5:0] pending_reg;
  wire [15:0] restore_data;
  wire [2:0] serial_shared_port_out_reg, serial_shared_port_oe_n_reg, serial_shared_port_in;
  int error_cnt = 0, checked = 0, i;
  logic [11:0] exp_q[$];
  logic [15:0] stk_q[$];
  // pins: pull-up unless the port drives low, or ext_drv pulls a released external pin low
  assign ext_shared_port_in = (ext_shared_port_oe_n_reg & ext_drv) | (~ext_shared_port_oe_n_reg & ext_shared_port_out_reg);
  assign serial_shared_port_in = serial_shared_port_oe_n_reg | serial_shared_port_out_reg;
  vic_ctrl u_vic_ctrl (.*, .serial_transfer_irq(int_src[3]), .counter_one_overflow_irq(int_src[2]),
    .counter_two_overflow_irq(int_src[1]), .divider_tick_irq(int_src[0]));
  vic_core_model u_vic_core_model (.*);
  initial forever #4 clk = ~clk;
  function [7:0] lfsr_next(input [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task tally_and_finish;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input string nm, input [15:0] e, input [15:0] a);
    checked++;
    if (a !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, a);
    end
  endtask
  task do_op(input [3:0] o, input [5:0] s);
    {return_from_irq, enable_and_clear_instr, disable_and_clear_instr, clear_latch_instr} = o;
    latch_clear_sel = s;
    step(1);
    {return_from_irq, enable_and_clear_instr, disable_and_clear_instr, clear_latch_instr} = 4'h0;
  endtask
  task set_mask(input [3:0] m);
    mask_wdata = m;
    mask_wr = 1;
    step(1);
    mask_wr = 0;
    step(1);
    check("mask", m, irq_enable_mask_reg);
  endtask
  task wr_ports(input [3:0] e, input [2:0] s);
    ext_port_wdata = e;
    ser_port_wdata = s;
    {ext_port_wr, ser_port_wr} = 2'h3;
    step(1);
    {ext_port_wr, ser_port_wr} = 2'h0;
  endtask
  // source 5 and 0 are pins, falling; the rest internal, rising
  task fire(input int n);
    if (n == 5)
      ext_drv[2] = 0;
    else if (n == 0)
      ext_drv[0] = 0;
    else
      int_src = 4'h1 << (n - 1);
    step(4);
    ext_drv = 4'hF;
    int_src = 4'h0;
    step(4);
  endtask
  task drain(input int n);
    int k;
    for (k = 0; k < 80 && exp_q.size() > n; k++)
      step(1);
    if (exp_q.size() > n)
    begin
      error_cnt++;
      $display("mismatch accept_wait expected %0d seen %0d", n, exp_q.size());
      tally_and_finish;
    end
    step(2);
  endtask
  // -------
  // monitor
  // -------
  always @(negedge clk)
  begin
    if (irq_accept_reg === 1'b1)
    begin
      stk_q.push_back({core_flags, core_pc});
      check("vector", exp_q.size() ? exp_q.pop_front() : 12'hFFF, vector_pc_reg);
    end
    if (restore_valid_reg === 1'b1)
      check("restore", stk_q.size() ? stk_q.pop_back() : 16'hFFFF, restore_data);
  end
  // --------
  // sequence
  // --------
  initial
  begin
    step(16);
    rst = 0;
    step(1);
    check("mask", 4'h0, irq_enable_mask_reg);
    check("pending", 6'h00, pending_reg);
    check("master", 1'b0, master_irq_enable_reg);
    check("ser_rdata", 4'hF, ser_port_rdata_reg);
    wr_ports(4'hF, 3'h7);
    set_mask(4'hF);
    for (i = 0; i < 6; i++)
      fire(i);
    check("pending", 6'h3F, pending_reg);
    exp_q.push_back(12'h002);
    do_op(4'h4, 6'h00);
    for (i = 0; i < 6; i++)
    begin
      drain(0);
      check("pending", 6'h3F >> (i + 1), pending_reg);
      check("master", 1'b0, master_irq_enable_reg);
      if (i < 5)
        exp_q.push_back(12'h004 + 2 * i);
      do_op(4'h8, 6'h00);
    end
    set_mask(4'hC);
    fire(0);
    fire(1);
    fire(2);
    check("pending", 6'h07, pending_reg);
    exp_q.push_back(12'h008);
    exp_q.push_back(12'h00A);
    set_mask(4'hE);
    drain(1);
    do_op(4'h8, 6'h00);
    drain(0);
    do_op(4'h8, 6'h00);
    step(1);
    do_op(4'h1, 6'h01);
    step(1);
    check("pending", 6'h00, pending_reg);
    // no mask bit at all: the high pin still needs only the master enable
    set_mask(4'h0);
    exp_q.push_back(12'h002);
    wr_ports(4'hB, 3'h7);
    drain(0);
    check("ext_oe_n", 4'hB, ext_shared_port_oe_n_reg);
    check("ext_rdata", 4'hB, ext_port_rdata_reg);
    wr_ports(4'hF, 3'h7);
    do_op(4'h8, 6'h00);
    for (i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      serial_enable = lfsr[6];
      serial_drive_low = lfsr[5:3];
      wr_ports(4'hF, lfsr[2:0]);
      step(4);
      check("ser_rdata", {1'b1, lfsr[2:0] & ~(lfsr[6] ? lfsr[5:3] : 3'h0)}, ser_port_rdata_reg);
    end
    tally_and_finish;
  end
endmodule
